/* File: rtl/srs_pkg.sv */
// Constants for the servo run/stop sequencer.
// Assumes a 50 MHz mclk and register port with one-cycle read latency.
package srs_pkg;
   localparam int          CLK_HZ          = 50_000_000;
   localparam int          DEB_US          = 1;
   localparam int          DEB_CYC         = (CLK_HZ / 1_000_000) * DEB_US;
   localparam logic [3:0]  ADDR_CTRL       = 4'h0;
   localparam logic [3:0]  ADDR_STATUS     = 4'h1;
   localparam logic [3:0]  ADDR_IRQ_STAT   = 4'h2;
   localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h3;
   localparam logic [3:0]  ADDR_TEST_OUT   = 4'h4;
   localparam logic [3:0]  ADDR_DISPLAY    = 4'h5;
   localparam int          CTRL_ABS_EN     = 0;
   localparam int          CTRL_TEST_MODE  = 1;
   localparam int          CTRL_AUTO_MODE  = 2;
   localparam logic [7:0]  CTRL_RESET      = 8'h00;
   localparam logic [7:0]  MASK_RESET      = 8'h00;
   localparam int          IRQ_ALARM       = 0;
   localparam int          IRQ_FSTOP_WARN  = 1;
   localparam int          IRQ_MPOFF_WARN  = 2;
   localparam int          IRQ_LIMIT       = 3;
   localparam int          IRQ_READY       = 4;
   localparam int          NUM_IRQ         = 5;
   localparam logic [7:0]  DISP_LETTER_B   = 8'h62;
   localparam logic [7:0]  STATION_DEFAULT = 8'h01;
   localparam int          NUM_DOUT        = 4;
   // Synchroniser reset levels follow each pin's idle level, so release of reset makes no false edge
   localparam logic [8:0]  PIN_IDLE        = 9'h03f;
   typedef enum logic [2:0] {
      SRS_OFF    = 3'b000,
      SRS_ON     = 3'b001,
      SRS_RUN    = 3'b011,
      SRS_DECEL  = 3'b010,
      SRS_BRAKE  = 3'b110,
      SRS_LOCKED = 3'b111
   } srs_state_t;
endpackage

/* File: rtl/srs_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous pin input; output follows once stages 2 and 3 agree.
`timescale 1ns/1ps
module srs_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic din,
   output logic      dout
);
   logic s1;
   logic s2;
   logic s3;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s1   <= RST_VAL;
         s2   <= RST_VAL;
         s3   <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            dout <= s3;
         end
      end
   end
endmodule

/* File: rtl/srs_sequencer.sv */
// Run/stop sequencer of a servo driver: servo-on, start, stop causes, test outputs.
// Assumes pins are asynchronous levels and power-on is signalled by rst_n release.
// Contract
// - Display shows b plus station number
// - First absolute power-up alarms, refuses servo-on
// - Position-lost alarm cleared only by power cycle
// - Servo-on off: base off, coast
// - Alarm: base off, dynamic brake
// - Forced stop off: brake, warning; code brakes only from a servo-on state, in SRS_OFF it only warns
// - Limit off: clear droop, servo-lock, reverse allowed
// - Auto mode select/pause off: decelerate
// - Servo-on state asserts ready
// - Start rotates motor in commanded direction
// - Forced digital output test mode
// - Brake interlock high means brake released
// - Main power loss stopped: warning, trouble kept
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
module srs_sequencer (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       servo_on_cmd,
   input  wire logic       fwd_start_cmd,
   input  wire logic       rev_start_cmd,
   input  wire logic       forced_stop_in,
   input  wire logic       fwd_limit_in,
   input  wire logic       rev_limit_in,
   input  wire logic       auto_manual_sel,
   input  wire logic       pause_restart_in,
   input  wire logic       main_power_ok,
   input  wire logic       abs_pos_valid,
   input  wire logic       ext_alarm,
   input  wire logic       motor_stopped,
   input  wire logic [7:0] station_num,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   output logic            irq,
   output logic            base_enable,
   output logic            dyn_brake,
   output logic            droop_clear,
   output logic            decel_stop,
   output logic            run_fwd,
   output logic            run_rev,
   output logic            ready_out,
   output logic            trouble_out,
   output logic            brake_interlock_out,
   output logic            abs_pos_lost_alarm,
   output logic            forced_stop_warning,
   output logic            main_power_off_warning,
   output logic     [3:0]  test_dout,
   output logic     [23:0] display_code
);
   localparam int NUM_DOUT_W = srs_pkg::NUM_DOUT;
   localparam int NUM_IRQ_W  = srs_pkg::NUM_IRQ;

   logic [8:0] pin_raw;
   logic [8:0] pin_s;
   assign pin_raw = {servo_on_cmd, fwd_start_cmd, rev_start_cmd, forced_stop_in, fwd_limit_in,
                     rev_limit_in, auto_manual_sel, pause_restart_in, main_power_ok};

   genvar gi;
   generate
      for (gi = 0; gi < 9; gi++) begin : g_sync
         srs_sync #(
            .RST_VAL (srs_pkg::PIN_IDLE[gi])
         ) u_sync (
            .mclk  (mclk),
            .rst_n (rst_n),
            .din   (pin_raw[gi]),
            .dout  (pin_s[gi])
         );
      end
   endgenerate

   logic s_son;
   logic s_fwd;
   logic s_rev;
   logic s_emg_ok;
   logic s_lim_f;
   logic s_lim_r;
   logic s_auto;
   logic s_go;
   logic s_mpwr;
   assign s_son    = pin_s[8];
   assign s_fwd    = pin_s[7];
   assign s_rev    = pin_s[6];
   assign s_emg_ok = pin_s[5];
   assign s_lim_f  = pin_s[4];
   assign s_lim_r  = pin_s[3];
   assign s_auto   = pin_s[2];
   assign s_go     = pin_s[1];
   assign s_mpwr   = pin_s[0];

   logic [7:0] ctrl;
   logic [7:0] irq_mask;
   logic [NUM_IRQ_W-1:0] irq_stat;
   logic [NUM_DOUT_W-1:0] test_reg;

   logic abs_en;
   logic test_mode;
   logic auto_mode;
   assign abs_en    = ctrl[srs_pkg::CTRL_ABS_EN];
   assign test_mode = ctrl[srs_pkg::CTRL_TEST_MODE];
   assign auto_mode = ctrl[srs_pkg::CTRL_AUTO_MODE];

   // The lost flag is only set after power-up; no register path clears it,
   // so only a fresh power-on reset releases it
   logic abs_checked;
   logic abs_lost;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         abs_checked <= 1'b0;
         abs_lost    <= 1'b0;
      end else if (!abs_checked && abs_en) begin
         abs_checked <= 1'b1;
         abs_lost    <= !abs_pos_valid;
      end
   end

   logic alarm_any;
   assign alarm_any = abs_lost || ext_alarm;

   srs_pkg::srs_state_t state;
   srs_pkg::srs_state_t next_state;

   logic start_ok;
   logic want_fwd;
   logic want_rev;
   logic hold_stop;
   assign start_ok  = (state == srs_pkg::SRS_ON) && !alarm_any && !test_mode;
   assign want_fwd  = s_fwd && !s_rev && s_lim_f;
   assign want_rev  = s_rev && !s_fwd && s_lim_r;
   assign hold_stop = auto_mode && (!s_auto || !s_go);

   always_comb begin
      next_state = state;
      case (state)
         srs_pkg::SRS_OFF: begin
            if (s_son && s_emg_ok && !alarm_any && !test_mode) begin
               next_state = srs_pkg::SRS_ON;
            end
         end
         srs_pkg::SRS_ON, srs_pkg::SRS_RUN, srs_pkg::SRS_DECEL, srs_pkg::SRS_LOCKED: begin
            if (alarm_any || !s_emg_ok) begin
               next_state = srs_pkg::SRS_BRAKE;
            end else if (!s_son) begin
               next_state = srs_pkg::SRS_OFF;
            end else if (state == srs_pkg::SRS_RUN && ((run_fwd && !s_lim_f) || (run_rev && !s_lim_r))) begin
               next_state = srs_pkg::SRS_LOCKED;
            end else if (state == srs_pkg::SRS_RUN && hold_stop) begin
               next_state = srs_pkg::SRS_DECEL;
            end else if (state == srs_pkg::SRS_RUN && !s_fwd && !s_rev) begin
               next_state = srs_pkg::SRS_ON;
            end else if (state == srs_pkg::SRS_DECEL && motor_stopped) begin
               next_state = srs_pkg::SRS_ON;
            end else if (state == srs_pkg::SRS_LOCKED && !s_fwd && !s_rev) begin
               next_state = srs_pkg::SRS_ON;
            end else if (state == srs_pkg::SRS_ON && start_ok && !hold_stop && (want_fwd || want_rev)) begin
               next_state = srs_pkg::SRS_RUN;
            end
         end
         srs_pkg::SRS_BRAKE: begin
            if (!alarm_any && s_emg_ok && !s_son && motor_stopped) begin
               next_state = srs_pkg::SRS_OFF;
            end
         end
         default: next_state = srs_pkg::SRS_OFF;
      endcase
   end

   logic next_run_fwd;
   logic next_run_rev;
   assign next_run_fwd = (state == srs_pkg::SRS_ON && next_state == srs_pkg::SRS_RUN) ? want_fwd
                       : (next_state == srs_pkg::SRS_RUN) ? run_fwd : 1'b0;
   assign next_run_rev = (state == srs_pkg::SRS_ON && next_state == srs_pkg::SRS_RUN) ? want_rev
                       : (next_state == srs_pkg::SRS_RUN) ? run_rev : 1'b0;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state   <= srs_pkg::SRS_OFF;
         run_fwd <= 1'b0;
         run_rev <= 1'b0;
      end else begin
         state   <= next_state;
         run_fwd <= next_run_fwd;
         run_rev <= next_run_rev;
      end
   end

   logic in_servo;
   assign in_servo = (state == srs_pkg::SRS_ON) || (state == srs_pkg::SRS_RUN) ||
                     (state == srs_pkg::SRS_DECEL) || (state == srs_pkg::SRS_LOCKED);

   // Warning for main power loss only counts while the motor is stopped
   logic mp_warn_set;
   assign mp_warn_set = !s_mpwr && motor_stopped;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         base_enable            <= 1'b0;
         dyn_brake              <= 1'b0;
         droop_clear            <= 1'b0;
         decel_stop             <= 1'b0;
         ready_out              <= 1'b0;
         trouble_out            <= 1'b0;
         brake_interlock_out    <= 1'b0;
         abs_pos_lost_alarm     <= 1'b0;
         forced_stop_warning    <= 1'b0;
         main_power_off_warning <= 1'b0;
      end else begin
         // An alarm cuts the stage and brakes at once, without waiting for the state change
         base_enable            <= in_servo && !alarm_any;
         dyn_brake              <= (state == srs_pkg::SRS_BRAKE) || alarm_any;
         droop_clear            <= (state == srs_pkg::SRS_RUN) && (next_state == srs_pkg::SRS_LOCKED);
         decel_stop             <= (state == srs_pkg::SRS_DECEL);
         ready_out              <= in_servo && !alarm_any;
         trouble_out            <= alarm_any;
         brake_interlock_out    <= in_servo && !alarm_any;
         abs_pos_lost_alarm     <= abs_lost;
         forced_stop_warning    <= !s_emg_ok;
         main_power_off_warning <= mp_warn_set;
      end
   end

   // Test outputs are only honoured with the power stage off, so a wiring check
   // can never coincide with a running motor
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         test_dout <= '0;
      end else begin
         test_dout <= (test_mode && !in_servo) ? test_reg : '0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         display_code <= 24'h000000;
      end else begin
         display_code <= {srs_pkg::DISP_LETTER_B, 4'h0, station_num[7:4], 4'h0, station_num[3:0]};
      end
   end

   logic [NUM_IRQ_W-1:0] ev;
   assign ev[srs_pkg::IRQ_ALARM]      = alarm_any && !trouble_out;
   assign ev[srs_pkg::IRQ_FSTOP_WARN] = !s_emg_ok && !forced_stop_warning;
   assign ev[srs_pkg::IRQ_MPOFF_WARN] = mp_warn_set && !main_power_off_warning;
   assign ev[srs_pkg::IRQ_LIMIT]      = droop_clear;
   assign ev[srs_pkg::IRQ_READY]      = in_servo && !ready_out;

   logic wr_ctrl;
   logic wr_stat;
   logic wr_mask;
   logic wr_test;
   assign wr_ctrl = reg_wr && (reg_addr == srs_pkg::ADDR_CTRL);
   assign wr_stat = reg_wr && (reg_addr == srs_pkg::ADDR_IRQ_STAT);
   assign wr_mask = reg_wr && (reg_addr == srs_pkg::ADDR_IRQ_MASK);
   assign wr_test = reg_wr && (reg_addr == srs_pkg::ADDR_TEST_OUT);

   logic [NUM_IRQ_W-1:0] clr_bits;
   assign clr_bits = wr_stat ? reg_wdata[NUM_IRQ_W-1:0] : '0;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl     <= srs_pkg::CTRL_RESET;
         irq_mask <= srs_pkg::MASK_RESET;
         test_reg <= '0;
         irq_stat <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= reg_wdata;
         end
         if (wr_mask) begin
            irq_mask <= reg_wdata;
         end
         if (wr_test) begin
            test_reg <= reg_wdata[NUM_DOUT_W-1:0];
         end
         // Set wins over a same-cycle clear
         irq_stat <= (irq_stat & ~clr_bits) | ev;
      end
   end

   assign irq = |(irq_stat & irq_mask[NUM_IRQ_W-1:0]);

   logic [7:0] status_word;
   assign status_word = {1'b0, 1'b0, abs_lost, trouble_out, forced_stop_warning,
                         main_power_off_warning, run_rev, run_fwd};

   logic [7:0] rd_mux;
   assign rd_mux = (reg_addr == srs_pkg::ADDR_CTRL)     ? ctrl
                 : (reg_addr == srs_pkg::ADDR_STATUS)   ? status_word
                 : (reg_addr == srs_pkg::ADDR_IRQ_STAT) ? {3'b000, irq_stat}
                 : (reg_addr == srs_pkg::ADDR_IRQ_MASK) ? irq_mask
                 : (reg_addr == srs_pkg::ADDR_TEST_OUT) ? {4'h0, test_reg}
                 : (reg_addr == srs_pkg::ADDR_DISPLAY)  ? {5'b00000, state}
                 : 8'h00;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
      end
   end
endmodule

/* File: testbench/srs_seq_sva.sv */
// Checker of the sequencer's stop, start and display relations.
// Assumes it is bound to srs_sequencer and sees only its ports.
`timescale 1ns/1ps
module srs_seq_chk (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        servo_on_cmd,
   input wire logic        forced_stop_in,
   input wire logic        fwd_limit_in,
   input wire logic [7:0]  station_num,
   input wire logic        base_enable,
   input wire logic        dyn_brake,
   input wire logic        run_fwd,
   input wire logic        run_rev,
   input wire logic        ready_out,
   input wire logic        brake_interlock_out,
   input wire logic        abs_pos_lost_alarm,
   input wire logic        forced_stop_warning,
   input wire logic [3:0]  test_dout,
   input wire logic [23:0] display_code
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Eight cycles cover the pin synchroniser plus state and output stages
   sequence s_fs_off; !forced_stop_in [*8]; endsequence
   sequence s_son_off; !servo_on_cmd [*8]; endsequence
   sequence s_lim_off; !fwd_limit_in [*8]; endsequence
   property p_alarm; abs_pos_lost_alarm [*3] |-> dyn_brake && !base_enable && !ready_out; endproperty
   property p_keep; abs_pos_lost_alarm |=> abs_pos_lost_alarm; endproperty
   property p_fstop; s_fs_off |-> forced_stop_warning && dyn_brake && !base_enable; endproperty
   property p_coast; s_son_off |-> !base_enable && !ready_out; endproperty
   property p_limit; s_lim_off |-> !run_fwd; endproperty
   property p_ready; ready_out |-> base_enable && !dyn_brake; endproperty
   property p_dir; run_fwd |-> !run_rev && base_enable && !abs_pos_lost_alarm; endproperty
   property p_test; test_dout != 4'h0 |-> !base_enable; endproperty
   property p_mbr; dyn_brake |-> !brake_interlock_out; endproperty
   property p_disp; $past(rst_n) && $stable(station_num) |->
      display_code == {8'h62, 4'h0, station_num[7:4], 4'h0, station_num[3:0]}; endproperty
   a_alarm: assert property (p_alarm) else $error("alarm stop wrong");
   a_keep: assert property (p_keep) else $error("alarm dropped");
   a_fstop: assert property (p_fstop) else $error("forced stop wrong");
   a_coast: assert property (p_coast) else $error("coast wrong");
   a_limit: assert property (p_limit) else $error("limit ignored");
   a_ready: assert property (p_ready) else $error("ready wrong");
   a_dir: assert property (p_dir) else $error("run wrong");
   a_test: assert property (p_test) else $error("test outputs live");
   a_mbr: assert property (p_mbr) else $error("brake interlock wrong");
   a_disp: assert property (p_disp) else $error("display wrong");
endmodule
bind srs_sequencer srs_seq_chk i_chk (.*);

/* File: testbench/srs_host.sv */
// Host command device model driving servo-on and the start commands.
// Assumes the bench calls its tasks; outputs change just after mclk rises.
`timescale 1ns/1ps
module srs_host (
   input  wire logic mclk,
   output logic      servo_on_cmd,
   output logic      fwd_start_cmd,
   output logic      rev_start_cmd
);
   initial begin
      servo_on_cmd = 1'b0;
      fwd_start_cmd = 1'b0;
      rev_start_cmd = 1'b0;
   end
   task automatic cmd(input logic son, input logic fs, input logic rs);
      @(posedge mclk);
      servo_on_cmd <= son;
      fwd_start_cmd <= fs;
      rev_start_cmd <= rs;
   endtask
   // Starts drop first so the motor is never left commanded while unpowered
   task automatic power_down();
      cmd(servo_on_cmd, 1'b0, 1'b0);
      repeat (8) @(posedge mclk);
      cmd(1'b0, 1'b0, 1'b0);
   endtask
endmodule

/* File: testbench/srs_sequencer_tb.sv */
// Self-checking bench of the run/stop sequencer.
// Assumes srs_host drives the commands; the bench drives pins and registers.
`timescale 1ns/1ps
module srs_sequencer_tb;
   logic mclk, rst_n, servo_on_cmd, fwd_start_cmd, rev_start_cmd, forced_stop_in, fwd_limit_in;
   logic rev_limit_in, auto_manual_sel, pause_restart_in, main_power_ok, abs_pos_valid, ext_alarm;
   logic motor_stopped, reg_wr, reg_rd, irq, base_enable, dyn_brake, droop_clear, decel_stop;
   logic run_fwd, run_rev, ready_out, trouble_out, brake_interlock_out, abs_pos_lost_alarm;
   logic forced_stop_warning, main_power_off_warning;
   logic [7:0]  station_num, reg_wdata, reg_rdata;
   logic [3:0]  reg_addr, test_dout;
   logic [23:0] display_code;
   int          err_total, compares, cyc;
   srs_sequencer i_dut (.*);
   srs_host i_host (.mclk(mclk), .servo_on_cmd(servo_on_cmd), .fwd_start_cmd(fwd_start_cmd),
      .rev_start_cmd(rev_start_cmd));
   always #10 mclk = ~mclk;
   task automatic end_sim();
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_total++;
         end_sim();
      end
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask
   // Covers the three-flop pin synchroniser plus state and output registers
   task automatic wt();
      repeat (10) @(posedge mclk);
      #1;
   endtask
   initial begin
      {mclk, rst_n, reg_wr, reg_rd, ext_alarm, abs_pos_valid, cyc, err_total, compares} = '0;
      {forced_stop_in, fwd_limit_in, rev_limit_in, auto_manual_sel} = 4'hf;
      {pause_restart_in, main_power_ok, motor_stopped} = 3'h7;
      abs_pos_valid = 1'b1;
      station_num = 8'h23;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      wt();
      chk(display_code, 24'h620203);
      rd(srs_pkg::ADDR_CTRL, srs_pkg::CTRL_RESET);
      rd(srs_pkg::ADDR_IRQ_MASK, srs_pkg::MASK_RESET);
      rd(4'hf, 8'h00);
      wr(srs_pkg::ADDR_IRQ_MASK, 8'h1f);
      i_host.cmd(1'b1, 1'b0, 1'b0);
      wt();
      chk(ready_out, 1'b1);
      rd(srs_pkg::ADDR_IRQ_STAT, 8'h10);
      wr(srs_pkg::ADDR_IRQ_STAT, 8'h10);
      chk(irq, 1'b0);
      $display("test power on done");
      i_host.cmd(1'b1, 1'b1, 1'b0);
      wt();
      chk({run_fwd, run_rev}, 2'b10);
      @(posedge mclk);
      fwd_limit_in <= 1'b0;
      wt();
      chk({run_fwd, base_enable}, 2'b01);
      rd(srs_pkg::ADDR_IRQ_STAT, 8'h08);
      i_host.cmd(1'b1, 1'b0, 1'b0);
      i_host.cmd(1'b1, 1'b0, 1'b1);
      wt();
      chk(run_rev, 1'b1);
      i_host.cmd(1'b1, 1'b0, 1'b0);
      fwd_limit_in <= 1'b1;
      wr(srs_pkg::ADDR_IRQ_STAT, 8'h1f);
      $display("test limit done");
      wr(srs_pkg::ADDR_CTRL, 8'h04);
      for (int i = 0; i < 2; i++) begin
         i_host.cmd(1'b1, 1'b1, 1'b0);
         motor_stopped <= 1'b0;
         wt();
         if (i == 0) pause_restart_in <= 1'b0;
         else auto_manual_sel <= 1'b0;
         wt();
         chk(decel_stop, 1'b1);
         i_host.cmd(1'b1, 1'b0, 1'b0);
         {pause_restart_in, auto_manual_sel} <= 2'b11;
         motor_stopped <= 1'b1;
         wt();
      end
      wr(srs_pkg::ADDR_CTRL, 8'h00);
      i_host.cmd(1'b1, 1'b1, 1'b1);
      wt();
      chk({run_fwd, run_rev}, 2'b00);
      i_host.cmd(1'b1, 1'b0, 1'b0);
      wt();
      $display("test decel done");
      forced_stop_in <= 1'b0;
      wt();
      chk({forced_stop_warning, dyn_brake, base_enable}, 3'b110);
      rd(srs_pkg::ADDR_IRQ_STAT, 8'h02);
      wr(srs_pkg::ADDR_IRQ_MASK, 8'h1d);
      chk(irq, 1'b0);
      wr(srs_pkg::ADDR_IRQ_MASK, 8'h1f);
      chk(irq, 1'b1);
      forced_stop_in <= 1'b1;
      i_host.power_down();
      wt();
      wr(srs_pkg::ADDR_IRQ_STAT, 8'h02);
      chk(irq, 1'b0);
      chk({base_enable, dyn_brake}, 2'b00);
      i_host.cmd(1'b0, 1'b1, 1'b0);
      wt();
      chk(run_fwd, 1'b0);
      i_host.cmd(1'b0, 1'b0, 1'b0);
      $display("test stop done");
      wr(srs_pkg::ADDR_CTRL, 8'h02);
      wr(srs_pkg::ADDR_TEST_OUT, 8'h0a);
      wt();
      chk(test_dout, 4'ha);
      wr(srs_pkg::ADDR_CTRL, 8'h00);
      ext_alarm <= 1'b1;
      wt();
      chk({dyn_brake, base_enable, brake_interlock_out}, 3'b100);
      ext_alarm <= 1'b0;
      main_power_ok <= 1'b0;
      wt();
      chk(main_power_off_warning, 1'b1);
      main_power_ok <= 1'b1;
      abs_pos_valid <= 1'b0;
      wr(srs_pkg::ADDR_CTRL, 8'h01);
      wt();
      chk(abs_pos_lost_alarm, 1'b1);
      i_host.cmd(1'b1, 1'b0, 1'b0);
      wt();
      chk(ready_out, 1'b0);
      wr(srs_pkg::ADDR_IRQ_STAT, 8'h1f);
      chk(abs_pos_lost_alarm, 1'b1);
      i_host.power_down();
      rst_n <= 1'b0;
      repeat (6) @(posedge mclk);
      abs_pos_valid <= 1'b1;
      rst_n <= 1'b1;
      wt();
      chk(abs_pos_lost_alarm, 1'b0);
      $display("test alarm done");
      end_sim();
   end
endmodule
